// *** src/fcfc_pkg.sv ***
`default_nettype none
package fcfc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_RX_CTL = 8'hc0;
   localparam logic [7:0] ADDR_TX_CTL = 8'hc4;
   localparam logic [7:0] ADDR_RX_END = 8'hc8;
   localparam logic [7:0] ADDR_TX_END = 8'hcc;
   localparam int BIT_EN = 32'h1f;
   localparam int BIT_RST = 32'h1e;
   localparam int BIT_SBAD = 32'h19;
   localparam int BIT_OVF = 32'h18;
   localparam int BIT_DROP = 32'h17;
   localparam int BIT_DIS = 32'h14;
   localparam logic [6:0] RX_END_RST = 7'h17;
   localparam logic [5:0] TX_END_RST = 6'h17;
   // ----------------------------------------
   // Sizing and accounting
   // ----------------------------------------
   localparam logic [17:0] END_MULT = 18'h00080;
   localparam logic [17:0] END_ADD = 18'h0007f;
   localparam logic [17:0] DW_BYTES = 18'h00004;
   localparam logic [17:0] DW_ROUND = 18'h00003;
   localparam logic [17:0] DW_MASK = 18'h3fffc;
   localparam logic [17:0] RX_META_BYTES = 18'h0000c;
   localparam logic [17:0] TX_META_BYTES = 18'h00008;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {REG_NONE, REG_RX_CTL, REG_TX_CTL, REG_RX_END, REG_TX_END} fcfc_reg_e;
   typedef enum logic {DIS_IDLE, DIS_WAIT} fcfc_dis_e;
endpackage
`default_nettype wire

// *** src/fcfc_dis_fsm.sv ***
`default_nettype none
module fcfc_dis_fsm import fcfc_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Control
   input wire logic en,
   input wire logic busy,
   // Status
   output logic done
);
   typedef struct packed {
      fcfc_dis_e st;
      logic en_q;
      logic done;
   } fcfc_dfsm_s;
   fcfc_dfsm_s r_q, r_d;

   always_comb begin
      r_d = r_q;
      r_d.en_q = en;
      r_d.done = 1'b0;
      case (r_q.st)
         DIS_IDLE: begin
            if (r_q.en_q && !en) begin
               // Frame in flight runs to its end first
               if (busy) begin
                  r_d.st = DIS_WAIT;
               end else begin
                  r_d.done = 1'b1;
               end
            end
         end
         DIS_WAIT: begin
            if (!busy) begin
               r_d.st = DIS_IDLE;
               r_d.done = 1'b1;
            end
         end
         default: r_d.st = DIS_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign done = r_q.done;

   property p_wait_done;
      @(posedge mclk) disable iff (!nrst) (r_q.st == DIS_WAIT && !busy) |=> done;
   endproperty
   a_wait_done: assert property (p_wait_done) else $error("drain end gave no done");

   property p_fall_idle;
      @(posedge mclk) disable iff (!nrst)
         ($fell(en) && r_q.st == DIS_IDLE && busy) |=> !done ##0 (r_q.st == DIS_WAIT);
   endproperty
   a_fall_idle: assert property (p_fall_idle) else $error("busy disable not deferred");
endmodule
`default_nettype wire

// *** src/fcfc_used_ctr.sv ***
`default_nettype none
module fcfc_used_ctr import fcfc_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clr,
   // Accounting
   input wire logic add_en,
   input wire logic [15:0] add_bytes,
   input wire logic sub_en,
   input wire logic [15:0] sub_bytes,
   // Level
   output logic [15:0] used
);
   typedef struct packed {
      logic [15:0] used;
   } fcfc_uctr_s;
   fcfc_uctr_s r_q, r_d;

   always_comb begin
      r_d = r_q;
      if (clr) begin
         r_d.used = '0;
      end else begin
         // Wraps silently; the source never overcommits
         r_d.used = r_q.used + (add_en ? add_bytes : 16'h0000)
                    - (sub_en ? sub_bytes : 16'h0000);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign used = r_q.used;

   property p_add;
      @(posedge mclk) disable iff (!nrst)
         (add_en && !sub_en && !clr) |=> used == $past(used) + $past(add_bytes);
   endproperty
   a_add: assert property (p_add) else $error("used space not raised by frame size");
endmodule
`default_nettype wire

// *** src/fcfc_top.sv ***
`default_nettype none
// What this block does
// - Receive enable set accepts filter frames; clear aborts them unwritten.
// - After enabling, storage starts only at the next whole frame.
// - Clearing receive enable mid-frame finishes that frame before disabling.
// - Frames aborted while disabled do not count as dropped.
// - Receive disable completion sets receive-disabled; software write clears it.
// - Receive reset bit self-clears, resets receive logic, flushes USB transmit pipe.
// - Store-bad-frames keeps MAC-errored frames; otherwise they are discarded.
// - Sticky dropped and overflow flags, each cleared by software write.
// - Used-space counts bytes: length rounded to DWORD plus command words.
// - Transmit enable set lets the FIFO send frames to the MAC.
// - Transmit disable mid-frame completes it, then sets transmit-disabled.
// - Half duplex retry after disable discards the frame, no more retries.
// - Transmit-disabled sets when the disabling after enable falls completes.
// - Transmit reset bit self-clears, resets transmit logic, flushes USB receive pipe.
// - End address is end field times 128 plus 127; fields reset 17h.
// - Receive end field is 7 bits; default is 17h, not the maximum 7Fh.
// - Transmit end field is 6 bits; default is 17h, not the maximum 3Fh.
module fcfc_top import fcfc_pkg::*; (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive filter engine side
   input wire logic rfe_valid,
   input wire logic rfe_sof,
   input wire logic rfe_eof,
   input wire logic rfe_err,
   input wire logic [15:0] rfe_len,
   // Receive FIFO and USB transmit pipeline
   output logic rx_wr,
   output logic rx_commit,
   output logic rx_discard,
   output logic utx_flush,
   input wire logic utx_rd_valid,
   input wire logic [15:0] utx_rd_bytes,
   output logic [13:0] rx_end_dw,
   // USB receive pipeline side
   input wire logic urx_commit,
   input wire logic [15:0] urx_bytes,
   output logic urx_flush,
   output logic [12:0] tx_end_dw,
   // MAC transmit side
   input wire logic mac_ready,
   input wire logic mac_done,
   input wire logic mac_retry,
   input wire logic mac_half_duplex,
   input wire logic [15:0] mac_bytes,
   output logic tx_start,
   output logic tx_discard
);
   typedef struct packed {
      logic rx_en;
      logic rx_sbad;
      logic rx_ovf;
      logic rx_drop;
      logic rx_dis;
      logic rx_rst;
      logic [6:0] rx_end;
      logic rx_take;
      logic [17:0] rx_need;
      logic rx_wr;
      logic rx_commit;
      logic rx_discard;
      logic [13:0] rx_end_dw;
      logic tx_en;
      logic tx_dis;
      logic tx_rst;
      logic [5:0] tx_end;
      logic tx_busy;
      logic [15:0] tx_frames;
      logic tx_start;
      logic tx_discard;
      logic [12:0] tx_end_dw;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } fcfc_top_s;
   fcfc_top_s r_q, r_d;

   logic [15:0] rx_used;
   logic [15:0] tx_used;
   logic rx_dis_done;
   logic tx_dis_done;
   logic rx_add_en;
   logic [15:0] rx_add;
   logic tx_add_en;
   logic [15:0] tx_add;
   logic tx_sub_en;
   logic sof_hit;
   logic take_now;
   logic fits;
   logic [17:0] need_now;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic fcfc_reg_e reg_of(input logic [7:0] a);
      case (a)
         ADDR_RX_CTL: reg_of = REG_RX_CTL;
         ADDR_TX_CTL: reg_of = REG_TX_CTL;
         ADDR_RX_END: reg_of = REG_RX_END;
         ADDR_TX_END: reg_of = REG_TX_END;
         default: reg_of = REG_NONE;
      endcase
   endfunction

   function automatic logic [17:0] end_dwords(input logic [6:0] e);
      end_dwords = 18'(e) * END_MULT + END_ADD;
   endfunction

   function automatic logic [17:0] round_dw(input logic [15:0] n);
      round_dw = (18'(n) + DW_ROUND) & DW_MASK;
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      r_d = r_q;
      rx_add_en = 1'b0;
      tx_add_en = 1'b0;
      tx_sub_en = 1'b0;
      r_d.rx_rst = 1'b0;
      r_d.tx_rst = 1'b0;
      r_d.rx_wr = 1'b0;
      r_d.rx_commit = 1'b0;
      r_d.rx_discard = 1'b0;
      r_d.tx_start = 1'b0;
      r_d.tx_discard = 1'b0;

      // APB: one access cycle, read word caught at setup
      r_d.pready = psel && !penable && !r_q.pready;
      if (psel && !penable && !r_q.pready) begin
         r_d.pslverr = (reg_of(paddr) == REG_NONE);
         r_d.prdata = '0;
         case (reg_of(paddr))
            REG_RX_CTL: begin
               r_d.prdata[BIT_EN] = r_q.rx_en;
               r_d.prdata[BIT_SBAD] = r_q.rx_sbad;
               r_d.prdata[BIT_OVF] = r_q.rx_ovf;
               r_d.prdata[BIT_DROP] = r_q.rx_drop;
               r_d.prdata[BIT_DIS] = r_q.rx_dis;
               r_d.prdata[15:0] = rx_used;
            end
            REG_TX_CTL: begin
               r_d.prdata[BIT_EN] = r_q.tx_en;
               r_d.prdata[BIT_DIS] = r_q.tx_dis;
               r_d.prdata[15:0] = tx_used;
            end
            REG_RX_END: r_d.prdata[6:0] = r_q.rx_end;
            REG_TX_END: r_d.prdata[5:0] = r_q.tx_end;
            default: r_d.prdata = '0;
         endcase
      end
      if (psel && penable && r_q.pready && pwrite) begin
         case (reg_of(paddr))
            REG_RX_CTL: begin
               r_d.rx_en = pwdata[BIT_EN];
               r_d.rx_sbad = pwdata[BIT_SBAD];
               r_d.rx_rst = pwdata[BIT_RST];
               if (pwdata[BIT_OVF]) begin
                  r_d.rx_ovf = 1'b0;
               end
               if (pwdata[BIT_DROP]) begin
                  r_d.rx_drop = 1'b0;
               end
               if (pwdata[BIT_DIS]) begin
                  r_d.rx_dis = 1'b0;
               end
            end
            REG_TX_CTL: begin
               r_d.tx_en = pwdata[BIT_EN];
               r_d.tx_rst = pwdata[BIT_RST];
               if (pwdata[BIT_DIS]) begin
                  r_d.tx_dis = 1'b0;
               end
            end
            REG_RX_END: r_d.rx_end = pwdata[6:0];
            REG_TX_END: r_d.tx_end = pwdata[5:0];
            default: r_d.rx_end = r_q.rx_end;
         endcase
      end

      // Receive admission, decided once per frame at its start
      sof_hit = rfe_valid && rfe_sof;
      need_now = sof_hit ? round_dw(rfe_len) + RX_META_BYTES : r_q.rx_need;
      fits = (18'(rx_used) + need_now) <= (end_dwords(r_q.rx_end) + 18'h00001) * DW_BYTES;
      take_now = sof_hit ? (r_q.rx_en && fits) : r_q.rx_take;
      r_d.rx_need = need_now;
      r_d.rx_take = take_now;
      r_d.rx_wr = rfe_valid && take_now;
      if (sof_hit && r_q.rx_en && !fits) begin
         r_d.rx_ovf = 1'b1;
         r_d.rx_drop = 1'b1;
      end
      if (rfe_valid && rfe_eof) begin
         r_d.rx_take = 1'b0;
         if (take_now) begin
            if (rfe_err && !r_q.rx_sbad) begin
               r_d.rx_discard = 1'b1;
               r_d.rx_drop = 1'b1;
            end else begin
               r_d.rx_commit = 1'b1;
               rx_add_en = 1'b1;
            end
         end
      end
      if (r_q.rx_rst) begin
         // Reset wins over a frame in flight; its words are flushed
         r_d.rx_take = 1'b0;
         r_d.rx_wr = 1'b0;
         r_d.rx_commit = 1'b0;
         rx_add_en = 1'b0;
      end
      if (rx_dis_done) begin
         r_d.rx_dis = 1'b1;
      end

      // Transmit scheduling
      tx_add_en = urx_commit && !r_q.tx_rst;
      if (r_q.tx_en && !r_q.tx_busy && r_q.tx_frames != 16'h0000 && mac_ready) begin
         r_d.tx_start = 1'b1;
         r_d.tx_busy = 1'b1;
      end
      if (r_q.tx_busy && mac_done) begin
         r_d.tx_busy = 1'b0;
         tx_sub_en = 1'b1;
      end else if (r_q.tx_busy && mac_retry && mac_half_duplex && !r_q.tx_en) begin
         r_d.tx_discard = 1'b1;
         r_d.tx_busy = 1'b0;
         tx_sub_en = 1'b1;
      end
      r_d.tx_frames = r_q.tx_frames + (tx_add_en ? 16'h0001 : 16'h0000)
                      - (tx_sub_en ? 16'h0001 : 16'h0000);
      if (r_q.tx_rst) begin
         r_d.tx_busy = 1'b0;
         r_d.tx_start = 1'b0;
         r_d.tx_frames = '0;
      end
      if (tx_dis_done) begin
         r_d.tx_dis = 1'b1;
      end

      // End addresses in DWORDs
      r_d.rx_end_dw = 14'(end_dwords(r_q.rx_end));
      r_d.tx_end_dw = 13'(end_dwords({1'b0, r_q.tx_end}));
   end

   assign rx_add = 16'(need_now);
   assign tx_add = 16'(round_dw(urx_bytes) + TX_META_BYTES);

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r_q <= '0;
         r_q.rx_end <= RX_END_RST;
         r_q.tx_end <= TX_END_RST;
         r_q.rx_end_dw <= 14'(end_dwords(RX_END_RST));
         r_q.tx_end_dw <= 13'(end_dwords({1'b0, TX_END_RST}));
      end else begin
         r_q <= r_d;
      end
   end

   // ----------------------------------------
   // Sub-blocks
   // ----------------------------------------
   fcfc_used_ctr u_rx_used (
      .mclk(mclk),
      .nrst(nrst),
      .clr(r_q.rx_rst),
      .add_en(rx_add_en),
      .add_bytes(rx_add),
      .sub_en(utx_rd_valid),
      .sub_bytes(utx_rd_bytes),
      .used(rx_used)
   );

   fcfc_used_ctr u_tx_used (
      .mclk(mclk),
      .nrst(nrst),
      .clr(r_q.tx_rst),
      .add_en(tx_add_en),
      .add_bytes(tx_add),
      .sub_en(tx_sub_en),
      .sub_bytes(mac_bytes),
      .used(tx_used)
   );

   fcfc_dis_fsm u_rx_dis (
      .mclk(mclk),
      .nrst(nrst),
      .en(r_q.rx_en),
      .busy(r_q.rx_take),
      .done(rx_dis_done)
   );

   fcfc_dis_fsm u_tx_dis (
      .mclk(mclk),
      .nrst(nrst),
      .en(r_q.tx_en),
      .busy(r_q.tx_busy),
      .done(tx_dis_done)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = r_q.prdata;
   assign pready = r_q.pready;
   assign pslverr = r_q.pslverr;
   assign rx_wr = r_q.rx_wr;
   assign rx_commit = r_q.rx_commit;
   assign rx_discard = r_q.rx_discard;
   assign utx_flush = r_q.rx_rst;
   assign urx_flush = r_q.tx_rst;
   assign rx_end_dw = r_q.rx_end_dw;
   assign tx_end_dw = r_q.tx_end_dw;
   assign tx_start = r_q.tx_start;
   assign tx_discard = r_q.tx_discard;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_rx_off;
      (rfe_valid && rfe_sof && !r_q.rx_en) |=> !rx_wr;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("frame written while disabled");

   property p_rx_mid;
      (rfe_valid && !rfe_sof && !r_q.rx_take) |=> !rx_wr;
   endproperty
   a_rx_mid: assert property (p_rx_mid) else $error("partial frame stored");

   property p_rx_finish;
      (r_q.rx_take && !r_q.rx_en && !r_q.rx_rst && rfe_valid && rfe_eof
       && !(rfe_err && !r_q.rx_sbad)) |=> rx_commit && rx_wr;
   endproperty
   a_rx_finish: assert property (p_rx_finish) else $error("frame cut by disable");

   property p_no_drop;
      (rfe_valid && rfe_sof && !r_q.rx_en && !r_q.rx_drop && !rfe_eof) |=> !r_q.rx_drop;
   endproperty
   a_no_drop: assert property (p_no_drop) else $error("disabled abort counted as drop");

   property p_rx_dis;
      rx_dis_done |=> r_q.rx_dis;
   endproperty
   a_rx_dis: assert property (p_rx_dis) else $error("receive disabled flag missed");

   property p_rx_rst;
      r_q.rx_rst |-> utx_flush ##1 (rx_used == 16'h0000 && !r_q.rx_rst);
   endproperty
   a_rx_rst: assert property (p_rx_rst) else $error("receive reset not applied");

   property p_bad;
      (r_q.rx_take && !r_q.rx_rst && rfe_valid && !rfe_sof && rfe_eof && rfe_err && !r_q.rx_sbad)
         |=> rx_discard && !rx_commit && r_q.rx_drop;
   endproperty
   a_bad: assert property (p_bad) else $error("bad frame kept");

   property p_ovf;
      (rfe_valid && rfe_sof && r_q.rx_en && !fits) |=> r_q.rx_ovf && !rx_wr;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");

   property p_tx_hold;
      !r_q.tx_en |=> !tx_start;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("frame sent while disabled");

   property p_retry;
      (r_q.tx_busy && !mac_done && mac_retry && mac_half_duplex && !r_q.tx_en)
         |=> tx_discard ##1 !tx_discard;
   endproperty
   a_retry: assert property (p_retry) else $error("retry after disable not discarded");

   property p_end;
      ##1 rx_end_dw == 14'($past(r_q.rx_end)) * 14'h0080 + 14'h007f;
   endproperty
   a_end: assert property (p_end) else $error("end address wrong");

   c_commit: cover property (rx_commit);
   c_ovf: cover property (rfe_valid && rfe_sof && r_q.rx_en && !fits);
   c_tx_dis: cover property (tx_dis_done && r_q.tx_frames != 16'h0000);
   c_retry: cover property (tx_discard);
endmodule
`default_nettype wire

// *** verif/fcfc_mac_model.sv ***
`default_nettype none
module fcfc_mac_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Scenario controls
   input wire logic retry_cmd,
   input wire logic [7:0] delay,
   input wire logic [15:0] footprint,
   // Block side
   input wire logic tx_start,
   output logic mac_ready,
   output logic mac_done,
   output logic mac_retry,
   output logic [15:0] mac_bytes
);
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic busy;
      logic hold;
      logic done;
      logic retry;
      logic [7:0] cnt;
   } fcfc_mac_s;
   fcfc_mac_s st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.retry = 1'b0;
      st_d.hold = st_q.done | st_q.retry;
      if (tx_start && !st_q.busy) begin
         st_d.busy = 1'b1;
         st_d.cnt = delay;
      end else if (st_q.busy && st_q.cnt == 8'h00) begin
         st_d.busy = 1'b0;
         st_d.retry = retry_cmd;
         st_d.done = !retry_cmd;
      end else if (st_q.busy) begin
         st_d.cnt = st_q.cnt - 8'h01;
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign mac_ready = !st_q.busy;
   assign mac_done = st_q.done;
   assign mac_retry = st_q.retry;
   // Count not held outside a frame: inverted so stale values never pass
   assign mac_bytes = (st_q.busy | st_q.done | st_q.retry | st_q.hold) ? footprint : ~footprint;
endmodule
`default_nettype wire

// *** verif/tb_frame_fifo_rx_tx_control.sv ***
`default_nettype none
module tb_frame_fifo_rx_tx_control import fcfc_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   localparam logic [31:0] EN = 32'h80000000, RST = 32'h40000000, SBAD = 32'h02000000;
   localparam logic [31:0] OVF = 32'h01000000, DROP = 32'h00800000, DIS = 32'h00100000;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, rerr;
   logic rfe_valid, rfe_sof, rfe_eof, rfe_err, utx_rd_valid, urx_commit;
   logic mac_half_duplex, retry_cmd, mac_ready, mac_done, mac_retry;
   logic rx_wr, rx_commit, rx_discard, utx_flush, urx_flush, tx_start, tx_discard;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic [15:0] rfe_len, utx_rd_bytes, urx_bytes, mac_bytes;
   logic [13:0] rx_end_dw;
   logic [12:0] tx_end_dw;
   int n_fail, checks, cyc, n_wr, n_com, n_dis, n_rxfl, n_txfl, n_st, n_txd;
   fcfc_top dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rfe_valid(rfe_valid), .rfe_sof(rfe_sof), .rfe_eof(rfe_eof), .rfe_err(rfe_err),
      .rfe_len(rfe_len), .rx_wr(rx_wr), .rx_commit(rx_commit), .rx_discard(rx_discard),
      .utx_flush(utx_flush), .utx_rd_valid(utx_rd_valid), .utx_rd_bytes(utx_rd_bytes),
      .rx_end_dw(rx_end_dw), .urx_commit(urx_commit), .urx_bytes(urx_bytes),
      .urx_flush(urx_flush), .tx_end_dw(tx_end_dw), .mac_ready(mac_ready),
      .mac_done(mac_done), .mac_retry(mac_retry), .mac_half_duplex(mac_half_duplex),
      .mac_bytes(mac_bytes), .tx_start(tx_start), .tx_discard(tx_discard));
   fcfc_mac_model mac (.mclk(mclk), .nrst(nrst), .retry_cmd(retry_cmd), .delay(8'h0a),
      .footprint(16'h0010), .tx_start(tx_start), .mac_ready(mac_ready),
      .mac_done(mac_done), .mac_retry(mac_retry), .mac_bytes(mac_bytes));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Pulse monitors; a pulse is one cycle, so each edge counts once
   always @(posedge mclk) begin
      n_wr += int'(rx_wr === 1'b1);
      n_com += int'(rx_commit === 1'b1);
      n_dis += int'(rx_discard === 1'b1);
      n_rxfl += int'(utx_flush === 1'b1);
      n_txfl += int'(urx_flush === 1'b1);
      n_st += int'(tx_start === 1'b1);
      n_txd += int'(tx_discard === 1'b1);
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         final_report();
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] m = 32'hffffffff);
      apb(1'b0, a, 32'h0);
      chk(nm, exp & m, rdat & m);
   endtask
   task automatic rx_word(input logic s, input logic e, input logic er, input logic [15:0] len);
      @(posedge mclk);
      rfe_valid <= 1'b1;
      rfe_sof <= s;
      rfe_eof <= e;
      rfe_err <= er;
      rfe_len <= len;
      @(posedge mclk);
      rfe_valid <= 1'b0;
      rfe_sof <= 1'b0;
      rfe_eof <= 1'b0;
   endtask
   task automatic frame(input logic [15:0] len, input logic er);
      rx_word(1'b1, 1'b0, 1'b0, len);
      rx_word(1'b0, 1'b1, er, 16'h0);
      repeat (3) @(posedge mclk);
   endtask
   task automatic push_tx(input logic [15:0] b);
      @(posedge mclk);
      urx_commit <= 1'b1;
      urx_bytes <= b;
      @(posedge mclk);
      urx_commit <= 1'b0;
   endtask
   task automatic wait_st(input int k);
      for (int i = 0; i < 100 && n_st < k; i++) @(posedge mclk);
   endtask
   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      {nrst, psel, penable, pwrite, rfe_valid, rfe_sof, rfe_eof, rfe_err} = '0;
      {utx_rd_valid, urx_commit, mac_half_duplex, retry_cmd} = '0;
      {paddr, pwdata, rfe_len, utx_rd_bytes, urx_bytes} = '0;
      {n_fail, checks, cyc, n_wr, n_com, n_dis, n_rxfl, n_txfl, n_st, n_txd} = '0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      rd("rx ctl", ADDR_RX_CTL, 32'h0);
      rd("tx ctl", ADDR_TX_CTL, 32'h0);
      rd("rx end", ADDR_RX_END, 32'h17);
      rd("tx end", ADDR_TX_END, 32'h17);
      chk("rx end dw", 32'h17 * 32'h80 + 32'h7f, {18'h0, rx_end_dw});
      chk("tx end dw", 32'h17 * 32'h80 + 32'h7f, {19'h0, tx_end_dw});
      rd("unmapped", 8'h10, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, rerr});
      wr(ADDR_RX_END, 32'hffffffff);
      rd("rx end width", ADDR_RX_END, 32'h7f);
      chk("rx end dw max", 32'h7f * 32'h80 + 32'h7f, {18'h0, rx_end_dw});
      wr(ADDR_TX_END, 32'hffffffff);
      rd("tx end width", ADDR_TX_END, 32'h3f);
      chk("tx end dw max", 32'h3f * 32'h80 + 32'h7f, {19'h0, tx_end_dw});
      wr(ADDR_RX_END, 32'h17);
      wr(ADDR_TX_END, 32'h17);
      frame(16'h5, 1'b0);
      chk("rx writes off", 32'h0, n_wr);
      rd("no drop when off", ADDR_RX_CTL, 32'h0);
      rx_word(1'b1, 1'b0, 1'b0, 16'h8);
      wr(ADDR_RX_CTL, EN);
      rx_word(1'b0, 1'b1, 1'b0, 16'h0);
      repeat (3) @(posedge mclk);
      chk("partial frame writes", 32'h0, n_wr + n_com);
      frame(16'h5, 1'b0);
      chk("rx writes", 32'h2, n_wr);
      chk("rx commits", 32'h1, n_com);
      rd("rx used", ADDR_RX_CTL, EN | 32'h14);
      @(posedge mclk);
      utx_rd_valid <= 1'b1;
      utx_rd_bytes <= 16'h14;
      @(posedge mclk);
      utx_rd_valid <= 1'b0;
      rd("rx used released", ADDR_RX_CTL, EN);
      frame(16'h4, 1'b1);
      chk("bad discard", 32'h1, n_dis);
      rd("bad not kept", ADDR_RX_CTL, EN | DROP);
      wr(ADDR_RX_CTL, EN | SBAD | DROP);
      frame(16'h4, 1'b1);
      chk("bad kept", 32'h2, n_com);
      rd("bad kept used", ADDR_RX_CTL, EN | SBAD | 32'h10);
      rx_word(1'b1, 1'b0, 1'b0, 16'h8);
      wr(ADDR_RX_CTL, 32'h0);
      rx_word(1'b0, 1'b1, 1'b0, 16'h0);
      repeat (3) @(posedge mclk);
      chk("finish on disable", 32'h3, n_com);
      rd("rx disabled", ADDR_RX_CTL, DIS | 32'h24);
      wr(ADDR_RX_CTL, DIS);
      rd("rx disabled clr", ADDR_RX_CTL, 32'h24);
      wr(ADDR_RX_CTL, RST);
      repeat (3) @(posedge mclk);
      chk("rx flush", 32'h1, n_rxfl);
      rd("rx after reset", ADDR_RX_CTL, 32'h0);
      wr(ADDR_RX_END, 32'h0);
      wr(ADDR_RX_CTL, RST);
      wr(ADDR_RX_CTL, EN);
      frame(16'h258, 1'b0);
      chk("no room writes", 32'h8, n_wr);
      rd("overflow", ADDR_RX_CTL, EN | OVF | DROP);
      wr(ADDR_RX_CTL, EN | OVF | DROP);
      rd("overflow clr", ADDR_RX_CTL, EN);
      wr(ADDR_RX_CTL, 32'h0);
      repeat (4) @(posedge mclk);
      rd("rx idle disable", ADDR_RX_CTL, DIS);
      wr(ADDR_TX_CTL, EN);
      push_tx(16'h6);
      rd("tx used", ADDR_TX_CTL, EN | 32'h10);
      wait_st(1);
      chk("tx start", 32'h1, n_st);
      repeat (20) @(posedge mclk);
      rd("tx done used", ADDR_TX_CTL, EN);
      push_tx(16'h6);
      wait_st(2);
      wr(ADDR_TX_CTL, 32'h0);
      rd("tx busy no flag", ADDR_TX_CTL, 32'h10);
      repeat (20) @(posedge mclk);
      rd("tx disabled", ADDR_TX_CTL, DIS);
      wr(ADDR_TX_CTL, DIS | EN);
      mac_half_duplex <= 1'b1;
      retry_cmd <= 1'b1;
      push_tx(16'h6);
      wait_st(3);
      wr(ADDR_TX_CTL, 32'h0);
      repeat (20) @(posedge mclk);
      chk("retry discard", 32'h1, n_txd);
      chk("no further retry", 32'h3, n_st);
      rd("retry disabled", ADDR_TX_CTL, DIS);
      push_tx(16'h6);
      repeat (10) @(posedge mclk);
      chk("no start when off", 32'h3, n_st);
      wr(ADDR_TX_CTL, DIS | RST);
      repeat (3) @(posedge mclk);
      chk("tx flush", 32'h1, n_txfl);
      rd("tx after reset", ADDR_TX_CTL, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
